// File: rtl/pwrg_top.sv
// Pulse width ramp generator with AHB-Lite register slave
// Contract
// - Approach mode steps working width by one every 512/1024/2048/4096 generator clocks.
// - Decrement mode 0x: in synchronous mode, second comparator event clears enable and stops output.
// - Decrement mode 10 is constant step, 11 is variable step.
// - Constant step decrements width by step field plus one.
// - Variable step decrements by one plus comparator period scaled by 64/32/16/8.
// - Nine-bit reload value, bit 8 in control two, low byte separate, resets zero.
// - Reload mode bit picks direct copy or gradual approach of working width; single pulse mode always copies directly.
// - Single pulse mode: enable write makes one pulse, hardware clears at timer end.
// - Synchronous mode: enabled, one pulse per first comparator event.
// - Generator clock is system clock over two, or over four with prescale set.
`timescale 1ns/1ps
`default_nettype none
module pwrg_top
    import pwrg_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Comparator events and pulse pin
    input  wire logic        first_comparator_event,
    input  wire logic        second_comparator_event,
    output logic             pulse_out
);
    // ****************************************************
    // Decode helpers
    // ****************************************************
    function automatic logic [7:0] reg_index(input logic [31:0] addr);
        reg_index = addr[9:2];
    endfunction : reg_index

    function automatic logic addr_mapped(input logic [31:0] addr);
        logic [7:0] i;
        i = addr[9:2];
        addr_mapped = (addr[31:10] == 22'h000000) && (addr[1:0] == 2'h0) &&
                      ((i == IDX_CTRL_ZERO) || (i == IDX_CTRL_TWO) || (i == IDX_RELOAD_LOW) ||
                       (i == IDX_TIMER_LOW) || (i == IDX_TIMER_HIGH));
    endfunction : addr_mapped

    function automatic logic [11:0] appr_last(input logic [1:0] rate);
        case (rate)
            2'h0:    appr_last = APPR_LAST_512;
            2'h1:    appr_last = APPR_LAST_1024;
            2'h2:    appr_last = APPR_LAST_2048;
            default: appr_last = APPR_LAST_4096;
        endcase
    endfunction : appr_last

    // ****************************************************
    // State
    // ****************************************************
    pwrg_state_s st;
    pwrg_state_s next_st;

    logic        tick;
    logic        first_comparator_event_evt;
    logic        second_comparator_event_evt;
    logic        addr_ok;
    logic [7:0]  addr_idx;
    logic [2:0]  shift;
    logic [15:0] dec;
    logic [15:0] period;
    logic        sync_mode;
    logic        start;

    assign hrdata    = st.hrdata;
    assign hreadyout = st.hreadyout;
    assign hresp     = 1'b0;
    assign pulse_out = st.active;

    // ****************************************************
    // Next-state logic
    // ****************************************************
    always_comb begin
        next_st   = st;
        addr_idx  = reg_index(haddr);
        addr_ok   = addr_mapped(haddr);
        sync_mode = st.cfg.pulse_output_mode;
        start     = 1'b0;
        shift     = SHIFT_SCALE_8;
        dec       = 16'h0000;
        period    = st.second_comparator_event_cnt;

        // Generator clock divider
        tick = (st.pre == (st.cfg.pulse_clock_prescale ? PRE_LAST_DIV4 : PRE_LAST_DIV2));
        next_st.pre = tick ? 2'h0 : st.pre + 2'h1;

        // Event edges
        next_st.first_comparator_event_prev = first_comparator_event;
        next_st.second_comparator_event_prev = second_comparator_event;
        first_comparator_event_evt = first_comparator_event & ~st.first_comparator_event_prev;
        second_comparator_event_evt = second_comparator_event & ~st.second_comparator_event_prev;

        // Second comparator period in generator clocks
        if (second_comparator_event_evt) begin
            next_st.second_comparator_event_cnt = 16'h0000;
        end else if (tick && (st.second_comparator_event_cnt != PERIOD_MAX)) begin
            next_st.second_comparator_event_cnt = st.second_comparator_event_cnt + 16'h0001;
        end

        // Working width: direct reload or gradual approach
        if (!st.cfg.reload_mode_select || !sync_mode) begin
            next_st.work     = st.cfg.reload_value;
            next_st.rate_cnt = 12'h000;
        end else if (tick) begin
            if (st.rate_cnt == appr_last(st.cfg.approach_rate)) begin
                next_st.rate_cnt = 12'h000;
                if (st.work < st.cfg.reload_value) begin
                    next_st.work = st.work + 9'h001;
                end else if (st.work > st.cfg.reload_value) begin
                    next_st.work = st.work - 9'h001;
                end
            end else begin
                next_st.rate_cnt = st.rate_cnt + 12'h001;
            end
        end

        // Width decrement on second comparator event
        if (sync_mode && second_comparator_event_evt) begin
            if (st.cfg.width_decrement_mode == WIDTH_DECREMENT_MODE_CONST) begin
                dec = {13'h0000, st.cfg.width_decrement_step} + 16'h0001;
            end else if (st.cfg.width_decrement_mode == WIDTH_DECREMENT_MODE_VAR) begin
                if (!st.cfg.width_decrement_step[2]) begin
                    shift = SHIFT_SCALE_64 - {1'b0, st.cfg.width_decrement_step[1:0]};
                end
                dec = (period >> shift) + 16'h0001;
                if (dec == 16'h0000) begin
                    dec = PERIOD_MAX;
                end
            end
            if (st.cfg.width_decrement_mode[1]) begin
                if (dec >= {7'h00, st.work}) begin
                    next_st.work = 9'h000;
                end else begin
                    next_st.work = st.work - dec[8:0];
                end
            end
        end

        // Pulse timer
        if (st.active) begin
            if (tick) begin
                if ((st.running_pulse_timer + 9'h001) >= st.work) begin
                    next_st.active = 1'b0;
                    next_st.running_pulse_timer = TIMER_RESET;
                    if (!sync_mode) begin
                        next_st.cfg.pulse_output_enable = 1'b0;
                    end
                end else begin
                    next_st.running_pulse_timer = st.running_pulse_timer + 9'h001;
                end
            end
        end else if (sync_mode && st.cfg.pulse_output_enable && first_comparator_event_evt) begin
            start = 1'b1;
        end else if (!sync_mode && st.cfg.pulse_output_enable) begin
            start = 1'b1;
        end
        if (start) begin
            if (st.work == 9'h000) begin
                if (!sync_mode) begin
                    next_st.cfg.pulse_output_enable = 1'b0;
                end
            end else begin
                next_st.active = 1'b1;
                next_st.running_pulse_timer = TIMER_RESET;
            end
        end

        // Stop mode: second comparator event kills output
        if (sync_mode && second_comparator_event_evt && !st.cfg.width_decrement_mode[1]) begin
            next_st.cfg.pulse_output_enable = 1'b0;
            next_st.active = 1'b0;
            next_st.running_pulse_timer = TIMER_RESET;
        end

        // Bus write data phase
        next_st.wr_pend = 1'b0;
        if (st.wr_pend) begin
            if (st.wr_idx == IDX_CTRL_ZERO) begin
                next_st.cfg.pulse_output_enable  = hwdata[CZ_ENABLE];
                next_st.cfg.reload_mode_select   = hwdata[CZ_RELOAD_MODE];
                next_st.cfg.pulse_output_mode    = hwdata[CZ_OUT_MODE];
                next_st.cfg.pulse_clock_prescale = hwdata[CZ_PRESCALE];
                if (!hwdata[CZ_ENABLE]) begin
                    next_st.active = 1'b0;
                    next_st.running_pulse_timer = TIMER_RESET;
                end
            end else if (st.wr_idx == IDX_CTRL_TWO) begin
                next_st.cfg.approach_rate        = hwdata[CT_RATE_LSB +: 2];
                next_st.cfg.width_decrement_mode = hwdata[CT_WIDTH_DECREMENT_MODE_LSB +: 2];
                next_st.cfg.width_decrement_step = hwdata[CT_STEP_LSB +: 3];
                next_st.cfg.reload_value[8]      = hwdata[CT_RELOAD_B8];
            end else if (st.wr_idx == IDX_RELOAD_LOW) begin
                next_st.cfg.reload_value[7:0]    = hwdata[7:0];
            end
        end

        // Bus address phase and read data
        next_st.hreadyout = 1'b1;
        next_st.hrdata    = 32'h00000000;
        if (hsel && hready && (htrans == HTRANS_NONSEQ_B || htrans == 2'h3) && addr_ok) begin
            if (hwrite) begin
                next_st.wr_pend = 1'b1;
                next_st.wr_idx  = addr_idx;
            end else if (addr_idx == IDX_CTRL_ZERO) begin
                next_st.hrdata[CZ_ENABLE]      = st.cfg.pulse_output_enable;
                next_st.hrdata[CZ_RELOAD_MODE] = st.cfg.reload_mode_select;
                next_st.hrdata[CZ_OUT_MODE]    = st.cfg.pulse_output_mode;
                next_st.hrdata[CZ_PRESCALE]    = st.cfg.pulse_clock_prescale;
            end else if (addr_idx == IDX_CTRL_TWO) begin
                next_st.hrdata[CT_RATE_LSB +: 2] = st.cfg.approach_rate;
                next_st.hrdata[CT_WIDTH_DECREMENT_MODE_LSB +: 2] = st.cfg.width_decrement_mode;
                next_st.hrdata[CT_STEP_LSB +: 3] = st.cfg.width_decrement_step;
                next_st.hrdata[CT_RELOAD_B8]     = st.cfg.reload_value[8];
            end else if (addr_idx == IDX_RELOAD_LOW) begin
                next_st.hrdata[7:0] = st.cfg.reload_value[7:0];
            end else if (addr_idx == IDX_TIMER_LOW) begin
                next_st.hrdata[7:0] = st.running_pulse_timer[7:0];
            end else if (addr_idx == IDX_TIMER_HIGH) begin
                next_st.hrdata[0] = st.running_pulse_timer[8];
            end
        end
        // Unused size input: single word transfers only
        if (hsize != 3'h2) begin
            next_st.hrdata = next_st.hrdata;
        end
    end

    // ****************************************************
    // State register
    // ****************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
            st.cfg.reload_value <= RELOAD_RESET;
            st.running_pulse_timer <= TIMER_RESET;
            st.work <= RELOAD_RESET;
            st.hreadyout <= 1'b1;
        end else begin
            st <= next_st;
        end
    end
endmodule : pwrg_top
`default_nettype wire

// File: rtl/pwrg_pkg.sv
// Package: register map, field layout, reset values and timing for the pulse width ramp generator
package pwrg_pkg;
    // ****************************************************
    // Register indices (byte address is four times index)
    // ****************************************************
    localparam logic [7:0]  IDX_CTRL_ZERO     = 8'hb1;
    localparam logic [7:0]  IDX_CTRL_TWO      = 8'hb2;
    localparam logic [7:0]  IDX_RELOAD_LOW    = 8'hb3;
    localparam logic [7:0]  IDX_TIMER_LOW     = 8'hb6;
    localparam logic [7:0]  IDX_TIMER_HIGH    = 8'hb7;
    // ****************************************************
    // Field positions
    // ****************************************************
    localparam int          CZ_ENABLE         = 7;
    localparam int          CZ_RELOAD_MODE    = 6;
    localparam int          CZ_OUT_MODE       = 4;
    localparam int          CZ_PRESCALE       = 3;
    localparam int          CT_RATE_LSB       = 6;
    localparam int          CT_WIDTH_DECREMENT_MODE_LSB       = 4;
    localparam int          CT_STEP_LSB       = 1;
    localparam int          CT_RELOAD_B8      = 0;
    // ****************************************************
    // Reset values and encodings
    // ****************************************************
    localparam logic [8:0]  RELOAD_RESET      = 9'h000;
    localparam logic [8:0]  TIMER_RESET       = 9'h000;
    localparam logic [1:0]  WIDTH_DECREMENT_MODE_CONST        = 2'h2;
    localparam logic [1:0]  WIDTH_DECREMENT_MODE_VAR          = 2'h3;
    // ****************************************************
    // Timing: generator clock divide and approach periods
    // ****************************************************
    localparam logic [1:0]  PRE_LAST_DIV2     = 2'h1;
    localparam logic [1:0]  PRE_LAST_DIV4     = 2'h3;
    localparam logic [11:0] APPR_LAST_512     = 12'h1ff;
    localparam logic [11:0] APPR_LAST_1024    = 12'h3ff;
    localparam logic [11:0] APPR_LAST_2048    = 12'h7ff;
    localparam logic [11:0] APPR_LAST_4096    = 12'hfff;
    localparam logic [2:0]  SHIFT_SCALE_64    = 3'h6;
    localparam logic [2:0]  SHIFT_SCALE_8     = 3'h3;
    localparam logic [15:0] PERIOD_MAX        = 16'hffff;
    localparam logic [1:0]  HTRANS_NONSEQ_B   = 2'h2;

    typedef struct packed {
        logic        pulse_output_enable;
        logic        reload_mode_select;
        logic        pulse_output_mode;
        logic        pulse_clock_prescale;
        logic [1:0]  approach_rate;
        logic [1:0]  width_decrement_mode;
        logic [2:0]  width_decrement_step;
        logic [8:0]  reload_value;
    } pwrg_cfg_s;

    typedef struct packed {
        pwrg_cfg_s   cfg;
        logic [1:0]  pre;
        logic [11:0] rate_cnt;
        logic [15:0] second_comparator_event_cnt;
        logic        first_comparator_event_prev;
        logic        second_comparator_event_prev;
        logic [8:0]  work;
        logic [8:0]  running_pulse_timer;
        logic        active;
        logic        wr_pend;
        logic [7:0]  wr_idx;
        logic [31:0] hrdata;
        logic        hreadyout;
    } pwrg_state_s;
endpackage : pwrg_pkg

// File: sim/pwrg_monitor.sv
// Checker: bus and pulse pin properties of the generator
`timescale 1ns/1ps
`default_nettype none
module pwrg_monitor
    import pwrg_pkg::*;
(
    // Bus
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Pulse side
    input wire logic        first_comparator_event,
    input wire logic        second_comparator_event,
    input wire logic        pulse_out
);
    // ****************************************
    // Snooped control bytes and pulse length
    // ****************************************
    logic        tk;
    logic        wr_q;
    logic        rd_q;
    logic [7:0]  idx_q;
    logic [7:0]  c0_s;
    logic [7:0]  c2_s;
    logic [11:0] hi_cnt;
    assign tk = hsel && hready && htrans[1] && haddr[31:10] == 22'h0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {wr_q, rd_q, idx_q, c0_s, c2_s, hi_cnt} <= '0;
        end else begin
            wr_q <= tk && hwrite;
            rd_q <= tk && !hwrite;
            idx_q <= haddr[9:2];
            if (wr_q && idx_q == IDX_CTRL_ZERO) c0_s <= hwdata[7:0];
            if (wr_q && idx_q == IDX_CTRL_TWO) c2_s <= hwdata[7:0];
            hi_cnt <= pulse_out ? hi_cnt + 12'h1 : 12'h0;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("error response seen");
    property p_nowait; hreadyout == 1'b1; endproperty
    a_nowait: assert property (p_nowait) else $error("wait state seen");
    property p_idle; !rd_q |-> hrdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside data phase");
    property p_upper; rd_q |-> hrdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_tmh; rd_q && idx_q == IDX_TIMER_HIGH |-> hrdata[31:1] == 31'h0; endproperty
    a_tmh: assert property (p_tmh) else $error("timer high byte too wide");
    property p_width; hi_cnt <= 12'h7fc; endproperty
    a_width: assert property (p_width) else $error("pulse longer than maximum");
    property p_stop; $rose(second_comparator_event) && c0_s[4] && !c2_s[5] |-> ##3 !pulse_out [*4]; endproperty
    a_stop: assert property (p_stop) else $error("pulse not stopped");
    property p_off; !c0_s[7] [*3] |-> !pulse_out; endproperty
    a_off: assert property (p_off) else $error("pulse while disabled");
endmodule : pwrg_monitor
bind pwrg_top pwrg_monitor pwrg_monitor_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .first_comparator_event(first_comparator_event),
    .second_comparator_event(second_comparator_event), .pulse_out(pulse_out)
);
`default_nettype wire

// File: sim/pwrg_partner.sv
// Partner model: comparator event sources and pulse pin observer
`timescale 1ns/1ps
`default_nettype none
module pwrg_partner (
    // Clock
    input  wire logic hclk,
    // Pulse pin and events
    input  wire logic pulse_out,
    output var logic  first_comparator_event,
    output var logic  second_comparator_event
);
    int unsigned width_q = 0;
    int unsigned pulses = 0;
    int unsigned run = 0;
    initial begin
        first_comparator_event = 1'b0;
        second_comparator_event = 1'b0;
    end
    // Length of each finished pulse in clocks
    always @(posedge hclk) begin
        if (pulse_out === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            width_q <= run;
            pulses <= pulses + 1;
            run <= 0;
        end
    end
    task automatic fire(input logic second);
        @(posedge hclk);
        second_comparator_event <= second;
        first_comparator_event <= ~second;
        repeat (2) @(posedge hclk);
        first_comparator_event <= 1'b0;
        second_comparator_event <= 1'b0;
    endtask : fire
endmodule : pwrg_partner
`default_nettype wire

// File: sim/pwrg_top_tb.sv
// Testbench: register access and pulse scenarios for the generator
`timescale 1ns/1ps
`default_nettype none
module pwrg_top_tb
    import pwrg_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, ev1, ev2, pulse_out;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int unsigned fail_count = 0;
    int unsigned total_checks = 0;
    int unsigned n0;
    logic [7:0]  regs [5] = '{IDX_CTRL_ZERO, IDX_CTRL_TWO, IDX_RELOAD_LOW, IDX_TIMER_LOW, IDX_TIMER_HIGH};
    pwrg_top pwrg_top_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .first_comparator_event(ev1),
        .second_comparator_event(ev2), .pulse_out(pulse_out)
    );
    pwrg_partner pwrg_partner_inst (
        .hclk(hclk), .pulse_out(pulse_out), .first_comparator_event(ev1), .second_comparator_event(ev2)
    );
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // ****************************************
    // Bus, compare and verdict tasks
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic pulse_chk(input int unsigned lo, input int unsigned hi);
        n0 = pwrg_partner_inst.pulses;
        for (int k = 0; k < 3000 && pwrg_partner_inst.pulses == n0; k++) @(posedge hclk);
        total_checks++;
        if (pwrg_partner_inst.pulses == n0 || pwrg_partner_inst.width_q < lo || pwrg_partner_inst.width_q > hi) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, pwrg_partner_inst.width_q, lo, hi);
        end
    endtask : pulse_chk
    task automatic xfer(input logic s, input logic [1:0] t, input logic w, input logic [31:0] a,
                        input logic [31:0] d);
        @(posedge hclk);
        hsel <= s;
        haddr <= a;
        htrans <= t;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        xfer(1'b1, HTRANS_NONSEQ_B, 1'b1, {22'h0, i, 2'h0}, {24'h0, d});
    endtask : wr
    task automatic rd_chk(input logic [7:0] i, input logic [7:0] e);
        xfer(1'b1, HTRANS_NONSEQ_B, 1'b0, {22'h0, i, 2'h0}, 32'h0);
        check(rd, {24'h0, e});
    endtask : rd_chk
    task automatic give_verdict;
        if (fail_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (20000) @(posedge hclk);
        fail_count++;
        give_verdict();
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (regs[k]) rd_chk(regs[k], 8'h00);
        xfer(1'b1, HTRANS_NONSEQ_B, 1'b1, 32'h400 | {22'h0, IDX_RELOAD_LOW, 2'h0}, 32'hff);
        rd_chk(IDX_RELOAD_LOW, 8'h00);
        // Unselected and idle transfers must be ignored
        xfer(1'b0, HTRANS_NONSEQ_B, 1'b1, {22'h0, IDX_RELOAD_LOW, 2'h0}, 32'h33);
        xfer(1'b1, 2'h0, 1'b1, {22'h0, IDX_RELOAD_LOW, 2'h0}, 32'h44);
        rd_chk(IDX_RELOAD_LOW, 8'h00);
        wr(IDX_TIMER_LOW, 8'hff);
        rd_chk(IDX_TIMER_LOW, 8'h00);
        wr(IDX_CTRL_TWO, 8'h01);
        rd_chk(IDX_CTRL_TWO, 8'h01);
        wr(IDX_CTRL_TWO, 8'h00);
        wr(IDX_RELOAD_LOW, 8'h05);
        wr(IDX_CTRL_ZERO, 8'h80);
        pulse_chk(4 * 2 + 1, 5 * 2);
        rd_chk(IDX_CTRL_ZERO, 8'h00);
        wr(IDX_CTRL_ZERO, 8'h88);
        pulse_chk(4 * 4 + 1, 5 * 4);
        rd_chk(IDX_CTRL_ZERO, 8'h08);
        wr(IDX_RELOAD_LOW, 8'h14);
        wr(IDX_CTRL_TWO, 8'h26);
        wr(IDX_CTRL_ZERO, 8'h90);
        pwrg_partner_inst.fire(1'b0);
        pulse_chk(19 * 2 + 1, 20 * 2);
        // Direct mode recopies the reload value, so decrements run in approach mode
        wr(IDX_CTRL_ZERO, 8'hd0);
        pwrg_partner_inst.fire(1'b1);
        pwrg_partner_inst.fire(1'b0);
        pulse_chk(15 * 2 + 1, 16 * 2);
        wr(IDX_CTRL_TWO, 8'h2e);
        pwrg_partner_inst.fire(1'b1);
        pwrg_partner_inst.fire(1'b0);
        pulse_chk(7 * 2 + 1, 8 * 2);
        // Variable step, scale 8: 114 ticks between events give a step of 15
        wr(IDX_CTRL_TWO, 8'h36);
        pwrg_partner_inst.fire(1'b1);
        wr(IDX_CTRL_ZERO, 8'h90);
        wr(IDX_CTRL_ZERO, 8'hd0);
        repeat (220) @(posedge hclk);
        pwrg_partner_inst.fire(1'b1);
        pwrg_partner_inst.fire(1'b0);
        pulse_chk(4 * 2 + 1, 5 * 2);
        wr(IDX_CTRL_TWO, 8'h2e);
        pwrg_partner_inst.fire(1'b1);
        pwrg_partner_inst.fire(1'b1);
        n0 = pwrg_partner_inst.pulses;
        pwrg_partner_inst.fire(1'b0);
        repeat (60) @(posedge hclk);
        check(pwrg_partner_inst.pulses - n0, 32'h0);
        wr(IDX_CTRL_TWO, 8'h00);
        wr(IDX_RELOAD_LOW, 8'h14);
        wr(IDX_CTRL_ZERO, 8'h90);
        pwrg_partner_inst.fire(1'b0);
        pwrg_partner_inst.fire(1'b1);
        pulse_chk(1, 19 * 2);
        rd_chk(IDX_CTRL_ZERO, 8'h10);
        wr(IDX_CTRL_ZERO, 8'hd0);
        wr(IDX_RELOAD_LOW, 8'h16);
        pwrg_partner_inst.fire(1'b0);
        pulse_chk(19 * 2 + 1, 21 * 2);
        repeat (1000) @(posedge hclk);
        pwrg_partner_inst.fire(1'b0);
        pulse_chk(20 * 2 + 1, 22 * 2);
        give_verdict();
    end
endmodule : pwrg_top_tb
`default_nettype wire
